// ===== hw/dpr_ctrl.sv
// controller end: command issue, refresh timing and clock enable
module dpr_ctrl (
    // link
    dpr_link_if.ctrl link,
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // request
    input wire logic req_valid,
    input wire dpr_pkg::dpr_req_t req_cmd,
    input wire logic [dpr_pkg::BA_W-1:0] req_bank,
    output logic req_ready,
    // configuration
    input wire logic temp_hot,
    input wire logic slow_exit,
    input wire logic odt_en,
    input wire logic dll_locked,
    // status
    output logic [dpr_pkg::NUM_BANKS-1:0] bank_open,
    output logic power_down,
    output logic self_refresh,
    output logic refresh_due,
    output logic dll_reset_req
);
    import dpr_pkg::*;

    typedef enum logic [2:0] {
        CS_RUN = 3'b001,
        CS_PD = 3'b010,
        CS_SR = 3'b100
    } dpr_cstate_t;

    dpr_cstate_t state_q;
    dpr_cmd_t cmd_q, cmd_d;
    logic cke_q, cke_d, a10_q, a10_d, odt_q, odt_d;
    logic [BA_W-1:0] ba_q;
    logic [NUM_BANKS-1:0] bank_q;
    logic [CNT_W-1:0] gap_q, rd_gap_q, burst_q, run_q, refi_q, quiet_q;
    logic [CNT_W-1:0] refi_len;
    logic apd_q, dll_lost_q, dll_rst_q;
    logic run, free, burst_idle, cke_free, odt_quiet, ok, take;
    logic due, auto_pre, auto_ref, auto_wake, go_down, go_up, free_ref;

    assign run = (state_q == CS_RUN);
    assign due = (refi_q == '0) && (state_q != CS_SR);
    assign free = run && (gap_q == '0) && !due;
    assign burst_idle = (burst_q == '0);
    assign cke_free = (run_q >= CKE_MIN_CYC);
    assign odt_quiet = !odt_q && (quiet_q >= ODT_OFF_CYC);

    // ==============================================================
    // request acceptance
    always_comb begin
        case (req_cmd)
            REQ_NOP: ok = run;
            REQ_ACT: ok = free && !bank_q[req_bank];
            REQ_PRE, REQ_PREA: ok = free && burst_idle;
            REQ_READ: ok = free && bank_q[req_bank] &&
                (rd_gap_q == '0);
            REQ_WRITE: ok = free && bank_q[req_bank];
            REQ_PD: ok = free && burst_idle && cke_free;
            REQ_SR: ok = free && burst_idle && cke_free &&
                (bank_q == '0) && odt_quiet;
            REQ_WAKE: ok = !run && cke_free;
            default: ok = 1'b0;
        endcase
    end

    assign req_ready = ok;
    assign take = req_valid && ok;

    // ==============================================================
    // refresh scheduling
    assign free_ref = run && (gap_q == '0) && burst_idle;
    assign auto_pre = due && free_ref && (bank_q != '0);
    assign auto_ref = due && free_ref && (bank_q == '0);
    assign auto_wake = due && (state_q == CS_PD) && cke_free;

    // ==============================================================
    // command and clock-enable choice
    always_comb begin
        cmd_d = CMD_NOP;
        a10_d = 1'b0;
        cke_d = cke_q;
        if (auto_pre) begin
            cmd_d = CMD_PRE;
            a10_d = 1'b1;
        end else if (auto_ref) begin
            cmd_d = CMD_REF;
        end else if (auto_wake) begin
            cke_d = 1'b1;
        end else if (take) begin
            case (req_cmd)
                REQ_ACT: cmd_d = CMD_ACT;
                REQ_PRE: cmd_d = CMD_PRE;
                REQ_PREA: begin
                    cmd_d = CMD_PRE;
                    a10_d = 1'b1;
                end
                REQ_READ: cmd_d = CMD_RD;
                REQ_WRITE: cmd_d = CMD_WR;
                REQ_PD: cke_d = 1'b0;
                REQ_SR: begin
                    cmd_d = CMD_REF;
                    cke_d = 1'b0;
                end
                REQ_WAKE: cke_d = 1'b1;
                default: cmd_d = CMD_NOP;
            endcase
        end
    end

    assign go_down = cke_q && !cke_d;
    assign go_up = !cke_q && cke_d;
    // odt low in power states, while self refresh is asked, until xsrd
    assign odt_d = odt_en && run && cke_d && (rd_gap_q == '0) &&
        !(req_valid && req_cmd == REQ_SR);

    // ==============================================================
    // link outputs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cmd_q <= CMD_NOP;
            a10_q <= 1'b0;
            ba_q <= '0;
            cke_q <= CKE_RST;
            odt_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            a10_q <= a10_d;
            ba_q <= req_bank;
            cke_q <= cke_d;
            odt_q <= odt_d;
        end
    end

    assign link.cke = cke_q;
    assign link.cs_n = (cmd_q == CMD_DES);
    assign link.ras_n = cmd_q[2];
    assign link.cas_n = cmd_q[1];
    assign link.we_n = cmd_q[0];
    assign link.ba = ba_q;
    assign link.a10 = a10_q;
    assign link.odt = odt_q;

    // ==============================================================
    // power state
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= CS_RUN;
        end else begin
            case (state_q)
                CS_RUN: begin
                    if (go_down) begin
                        state_q <= (cmd_d == CMD_REF) ? CS_SR : CS_PD;
                    end
                end
                CS_PD, CS_SR: begin
                    if (go_up) begin
                        state_q <= CS_RUN;
                    end
                end
                default: state_q <= CS_RUN;
            endcase
        end
    end

    // entry kind and dll state, kept across power-down
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            apd_q <= 1'b0;
            dll_lost_q <= 1'b0;
            dll_rst_q <= 1'b0;
        end else begin
            dll_rst_q <= go_up && (state_q == CS_PD) && dll_lost_q;
            if (go_down) begin
                apd_q <= (bank_q != '0);
                dll_lost_q <= !dll_locked;
            end
        end
    end

    // ==============================================================
    // open rows
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bank_q <= '0;
        end else if (cmd_d == CMD_ACT) begin
            bank_q[req_bank] <= 1'b1;
        end else if (cmd_d == CMD_PRE) begin
            if (a10_d) begin
                bank_q <= '0;
            end else begin
                bank_q[req_bank] <= 1'b0;
            end
        end
    end

    // ==============================================================
    // command spacing
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            gap_q <= '0;
        end else if (go_up) begin
            // after self refresh wait the full 200 clocks before any command, else tXP
            gap_q <= (state_q == CS_SR) ? XSRD_CYC - ONE_CYC :
                XP_CYC - ONE_CYC;
        end else if (cmd_d == CMD_PRE) begin
            gap_q <= a10_d ? RPA_CYC - ONE_CYC : RP_CYC - ONE_CYC;
        end else if (cmd_d == CMD_REF && cke_d) begin
            gap_q <= RFC_CYC - ONE_CYC;
        end else if (cmd_d == CMD_ACT) begin
            gap_q <= ACT_GAP_CYC - ONE_CYC;
        end else if (gap_q != '0) begin
            gap_q <= gap_q - ONE_CYC;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_gap_q <= '0;
        end else if (go_up && state_q == CS_SR) begin
            rd_gap_q <= XSRD_CYC - ONE_CYC;
        end else if (go_up) begin
            rd_gap_q <= !apd_q ? XP_CYC - ONE_CYC :
                slow_exit ? XARDS_CYC - ONE_CYC :
                XARD_CYC - ONE_CYC;
        end else if (rd_gap_q != '0) begin
            rd_gap_q <= rd_gap_q - ONE_CYC;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            burst_q <= '0;
        end else if (cmd_d == CMD_RD || cmd_d == CMD_WR) begin
            burst_q <= BURST_CYC - ONE_CYC;
        end else if (burst_q != '0) begin
            burst_q <= burst_q - ONE_CYC;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            run_q <= CKE_MIN_CYC;
        end else if (cke_d != cke_q) begin
            run_q <= ONE_CYC;
        end else if (run_q < CKE_MIN_CYC) begin
            run_q <= run_q + ONE_CYC;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            quiet_q <= '0;
        end else if (odt_q) begin
            quiet_q <= '0;
        end else if (quiet_q < ODT_OFF_CYC) begin
            quiet_q <= quiet_q + ONE_CYC;
        end
    end

    // ==============================================================
    // refresh interval
    assign refi_len = temp_hot ? REFI_HOT_CYC : REFI_CYC;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            refi_q <= REFI_CYC - ONE_CYC;
        end else if (auto_ref || state_q == CS_SR) begin
            refi_q <= refi_len - ONE_CYC;
        end else if (temp_hot && refi_q > REFI_HOT_CYC - ONE_CYC) begin
            refi_q <= REFI_HOT_CYC - ONE_CYC;
        end else if (refi_q != '0) begin
            refi_q <= refi_q - ONE_CYC;
        end
    end

    // ==============================================================
    // status
    // clock runs free from one source, so it is stable around every
    // power state and never changes frequency across power-down
    assign bank_open = bank_q;
    assign power_down = (state_q == CS_PD);
    assign self_refresh = (state_q == CS_SR);
    assign refresh_due = due;
    assign dll_reset_req = dll_rst_q;
endmodule

// ===== hw/dpr_pkg.sv
// shared constants and types for both ddr2 refresh/power-down ends
// ==================================================================
// Overview of operation
// - A10 high precharges all, else one bank
// - activate a bank before read or write
// - wait tRP single, tRPA after precharge all
// - refresh at most every 7.8125us on average
// - refresh starts at command, lasts tRFC
// - above 85C refresh interval 3.9us
// - refresh with cke low enters self refresh
// - clock stable one period around self refresh
// - only nop/deselect for tXSNR after exit
// - nop/deselect 200 clocks after self refresh
// - non-read after tXSNR, read after tXSRD
// - exit delays count from first cke high
// - cke high until tXSRD unless re-entering
// - odt off before and after self refresh
// - self refresh only with all banks idle
// - cke high until burst completes
// - cke low with nop enters power-down
// - idle banks precharge, open row active
// - buffers off, dll frozen, reset if unlocked
// - active power-down exits at same frequency
// - cke keeps each level three edges
// - tXP non-read, tXARD or tXARDS read
package dpr_pkg;
    // ==============================================================
    // geometry
    localparam int NUM_BANKS = 8;
    localparam int BA_W = 3;
    localparam int CNT_W = 12;
    // ==============================================================
    // times, ps or clocks
    localparam int CLK_PS = 4000;
    localparam int T_RP_PS = 15000;
    localparam int T_RPA_PS = 17500;
    localparam int T_RFC_PS = 197500;
    localparam int T_XSNR_PS = 207500;
    localparam int T_REFI_PS = 7812500;
    localparam int T_REFI_HOT_PS = 3900000;
    localparam int XSRD_CK = 200;
    localparam int XP_CK = 2;
    localparam int XARD_CK = 2;
    localparam int XARDS_CK = 7;
    localparam int CKE_MIN_CK = 3;
    localparam int ACT_GAP_CK = 1;
    localparam int BURST_CK = 8;
    localparam int ODT_OFF_CK = 3;

    function automatic int cyc_up(input int ps);
        int c;
        c = (ps + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_dn(input int ps);
        int c;
        c = ps / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // ==============================================================
    // cycle counts
    localparam logic [CNT_W-1:0] RP_CYC = CNT_W'(cyc_up(T_RP_PS));
    localparam logic [CNT_W-1:0] RPA_CYC = CNT_W'(cyc_up(T_RPA_PS));
    localparam logic [CNT_W-1:0] RFC_CYC = CNT_W'(cyc_up(T_RFC_PS));
    localparam logic [CNT_W-1:0] XSNR_CYC = CNT_W'(cyc_up(T_XSNR_PS));
    localparam logic [CNT_W-1:0] REFI_CYC = CNT_W'(cyc_dn(T_REFI_PS));
    localparam logic [CNT_W-1:0] REFI_HOT_CYC =
        CNT_W'(cyc_dn(T_REFI_HOT_PS));
    localparam logic [CNT_W-1:0] XSRD_CYC = CNT_W'(XSRD_CK);
    localparam logic [CNT_W-1:0] XP_CYC = CNT_W'(XP_CK);
    localparam logic [CNT_W-1:0] XARD_CYC = CNT_W'(XARD_CK);
    localparam logic [CNT_W-1:0] XARDS_CYC = CNT_W'(XARDS_CK);
    localparam logic [CNT_W-1:0] CKE_MIN_CYC = CNT_W'(CKE_MIN_CK);
    localparam logic [CNT_W-1:0] ACT_GAP_CYC = CNT_W'(ACT_GAP_CK);
    localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(BURST_CK);
    localparam logic [CNT_W-1:0] ODT_OFF_CYC = CNT_W'(ODT_OFF_CK);
    localparam logic [CNT_W-1:0] ONE_CYC = 12'h001;
    localparam logic CKE_RST = 1'b1;

    // ==============================================================
    // link commands, {ras_n, cas_n, we_n} with cs_n low, deselect with cs_n high
    typedef enum logic [3:0] {
        CMD_LM = 4'h0,
        CMD_REF = 4'h1,
        CMD_PRE = 4'h2,
        CMD_ACT = 4'h3,
        CMD_WR = 4'h4,
        CMD_RD = 4'h5,
        CMD_NOP = 4'h7,
        CMD_DES = 4'h8
    } dpr_cmd_t;

    // controller user requests
    typedef enum logic [3:0] {
        REQ_NOP = 4'h0,
        REQ_ACT = 4'h1,
        REQ_PRE = 4'h2,
        REQ_PREA = 4'h3,
        REQ_READ = 4'h4,
        REQ_WRITE = 4'h5,
        REQ_PD = 4'h6,
        REQ_SR = 4'h7,
        REQ_WAKE = 4'h8
    } dpr_req_t;

    function automatic dpr_cmd_t dpr_decode(input logic cs_n,
        input logic ras_n, input logic cas_n, input logic we_n);
        if (cs_n) begin
            return CMD_DES;
        end
        return dpr_cmd_t'({1'b0, ras_n, cas_n, we_n});
    endfunction
endpackage

// ===== hw/dpr_link_if.sv
// command and clock-enable link between controller and device
interface dpr_link_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [dpr_pkg::BA_W-1:0] ba;
    logic a10;
    logic odt;

    modport ctrl (
        output cke, cs_n, ras_n, cas_n, we_n, ba, a10, odt
    );
    modport dev (
        input cke, cs_n, ras_n, cas_n, we_n, ba, a10, odt
    );
endinterface

// ===== hw/dpr_dev.sv
// device end: bank state, refresh, self refresh and power-down
module dpr_dev (
    // link
    dpr_link_if.dev link,
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // state
    output logic [dpr_pkg::NUM_BANKS-1:0] bank_open,
    output logic pd_precharge,
    output logic pd_active,
    output logic self_refresh,
    output logic refreshing,
    output logic dll_frozen,
    output logic buffers_on,
    output logic exit_busy,
    // errors
    output logic cmd_error,
    output logic cke_error
);
    import dpr_pkg::*;

    typedef enum logic [3:0] {
        DS_ON = 4'b0001,
        DS_PPD = 4'b0010,
        DS_APD = 4'b0100,
        DS_SR = 4'b1000
    } dpr_dstate_t;

    dpr_dstate_t state_q;
    dpr_cmd_t cmd;
    logic cke_prev_q;
    logic [NUM_BANKS-1:0] bank_q;
    logic [CNT_W-1:0] rfc_q, xsnr_q, xsrd_q, pdx_q, run_q;
    logic live, is_nop, enter, leave, idle, err_d, bank_hit;

    assign cmd = dpr_decode(link.cs_n, link.ras_n, link.cas_n, link.we_n);
    assign is_nop = (cmd == CMD_NOP) || (cmd == CMD_DES);
    assign live = (state_q == DS_ON) && cke_prev_q && link.cke;
    assign enter = (state_q == DS_ON) && cke_prev_q && !link.cke;
    assign leave = (state_q != DS_ON) && !cke_prev_q && link.cke;
    assign idle = (bank_q == '0);
    assign bank_hit = bank_q[link.ba];

    // ==============================================================
    // power state
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= DS_ON;
        end else begin
            case (state_q)
                DS_ON: begin
                    if (enter && cmd == CMD_REF && idle) begin
                        state_q <= DS_SR;
                    end else if (enter && is_nop) begin
                        state_q <= idle ? DS_PPD : DS_APD;
                    end
                end
                DS_PPD, DS_APD, DS_SR: begin
                    if (leave) begin
                        state_q <= DS_ON;
                    end
                end
                default: state_q <= DS_ON;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cke_prev_q <= CKE_RST;
        end else begin
            cke_prev_q <= link.cke;
        end
    end

    // ==============================================================
    // open rows per bank
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bank_q <= '0;
        end else if (live && cmd == CMD_ACT) begin
            bank_q[link.ba] <= 1'b1;
        end else if (live && cmd == CMD_PRE) begin
            if (link.a10) begin
                bank_q <= '0;
            end else begin
                bank_q[link.ba] <= 1'b0;
            end
        end
    end

    // ==============================================================
    // refresh and exit delay counters
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rfc_q <= '0;
        end else if (live && cmd == CMD_REF) begin
            rfc_q <= RFC_CYC - ONE_CYC;
        end else if (rfc_q != '0) begin
            rfc_q <= rfc_q - ONE_CYC;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            xsnr_q <= '0;
            xsrd_q <= '0;
        end else if (leave && state_q == DS_SR) begin
            xsnr_q <= XSNR_CYC - ONE_CYC;
            xsrd_q <= XSRD_CYC - ONE_CYC;
        end else begin
            if (xsnr_q != '0) begin
                xsnr_q <= xsnr_q - ONE_CYC;
            end
            if (xsrd_q != '0) begin
                xsrd_q <= xsrd_q - ONE_CYC;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pdx_q <= '0;
        end else if (leave && state_q != DS_SR) begin
            pdx_q <= XP_CYC - ONE_CYC;
        end else if (pdx_q != '0) begin
            pdx_q <= pdx_q - ONE_CYC;
        end
    end

    // ==============================================================
    // protocol checks
    always_comb begin
        err_d = 1'b0;
        if (live) begin
            if ((cmd == CMD_RD || cmd == CMD_WR) && !bank_hit) begin
                err_d = 1'b1;
            end
            if (!is_nop && (xsnr_q != '0 || rfc_q != '0 ||
                pdx_q != '0)) begin
                err_d = 1'b1;
            end
            if (cmd == CMD_RD && xsrd_q != '0) begin
                err_d = 1'b1;
            end
        end
        if (enter && !(is_nop || (cmd == CMD_REF && idle))) begin
            err_d = 1'b1;
        end
        if (leave && !is_nop) begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cmd_error <= 1'b0;
        end else begin
            cmd_error <= err_d;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            run_q <= CKE_MIN_CYC;
            cke_error <= 1'b0;
        end else begin
            cke_error <= (link.cke != cke_prev_q) &&
                (run_q < CKE_MIN_CYC);
            if (link.cke != cke_prev_q) begin
                run_q <= ONE_CYC;
            end else if (run_q < CKE_MIN_CYC) begin
                run_q <= run_q + ONE_CYC;
            end
        end
    end

    // ==============================================================
    // status
    assign bank_open = bank_q;
    assign pd_precharge = state_q[1];
    assign pd_active = state_q[2];
    assign self_refresh = state_q[3];
    assign refreshing = (rfc_q != '0) || state_q[3];
    assign dll_frozen = state_q[1];
    assign buffers_on = state_q[0];
    assign exit_busy = (xsrd_q != '0) || (pdx_q != '0);
endmodule

// ===== sim/dpr_link_assertions.sv
// link-side timing checks for the refresh and power-down link
module dpr_link_assertions
    import dpr_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // link
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [dpr_pkg::BA_W-1:0] ba,
    input wire logic a10,
    input wire logic odt
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // ==============================================================
    // helpers
    logic [3:0] c;
    logic [3:0] last_q;
    logic [7:0] gap_q;
    logic [7:0] sr_q;
    logic cke_q;
    logic in_sr_q;
    assign c = {cs_n, ras_n, cas_n, we_n};
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            last_q <= 4'h7;
            gap_q <= 8'hff;
        end else if (c != 4'h7) begin
            last_q <= c;
            gap_q <= 8'h01;
        end else if (gap_q != 8'hff) begin
            gap_q <= gap_q + 8'h01;
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cke_q <= 1'b1;
            in_sr_q <= 1'b0;
            sr_q <= 8'h00;
        end else begin
            cke_q <= cke;
            in_sr_q <= (cke_q && !cke && c == 4'h1) || (in_sr_q && !cke);
            if (in_sr_q && cke) begin
                sr_q <= 8'hc7;
            end else if (sr_q != 8'h00) begin
                sr_q <= sr_q - 8'h01;
            end
        end
    end
    // ==============================================================
    // sequences and assertions
    sequence pre_one_s;
        cke && c == 4'h2 && !a10;
    endsequence
    sequence pre_all_s;
        cke && c == 4'h2 && a10;
    endsequence
    sequence sr_entry_s;
        cke_q && !cke && c == 4'h1;
    endsequence
    AST_CKE_HOLD: assert property ($changed(cke) |=> $stable(cke) [*2])
        else $error("cke level held under three edges");
    AST_CKE_FALL: assert property ($fell(cke) |-> c == 4'h7 || c == 4'h1)
        else $error("cke fell without nop or refresh");
    AST_CKE_RISE: assert property ($rose(cke) |-> c == 4'h7)
        else $error("cke rose without nop");
    AST_SR_QUIET: assert property (sr_q != 8'h00 |-> c == 4'h7 && cke)
        else $error("command or cke low inside self refresh exit");
    AST_ODT_SR: assert property (sr_entry_s |-> !odt && !$past(odt) && !$past(odt, 2))
        else $error("termination on at self refresh entry");
    AST_ODT_EXIT: assert property (in_sr_q || sr_q != 8'h00 |-> !odt)
        else $error("termination on during self refresh");
    AST_RP_GAP: assert property (pre_one_s |=> c == 4'h7 [*3])
        else $error("bank precharge spacing short");
    AST_RPA_GAP: assert property (pre_all_s |=> c == 4'h7 [*4])
        else $error("precharge all spacing short");
    AST_RFC_GAP: assert property (c != 4'h7 && last_q == 4'h1 |-> gap_q >= 8'h32)
        else $error("command inside refresh period");
    AST_BURST_CKE: assert property ($fell(cke) && last_q[3:1] == 3'h2 |-> gap_q >= 8'h08)
        else $error("cke dropped during burst");
endmodule

// ===== sim/ddr2_precharge_refresh_powerdown_tb.sv
// top bench: controller and device joined across the link
module ddr2_precharge_refresh_powerdown_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dpr_pkg::*;
    logic clock, resetn, req_valid, req_ready, temp_hot, dll_locked;
    logic c_sr, d_sr, pd_p, pd_a, refr, dll_fz, buf_on, busy, rst_rq;
    logic cmd_err, cke_err, c_pd;
    dpr_req_t req_cmd;
    logic [2:0] req_bank;
    logic [7:0] c_open, d_open, m_open;
    logic [15:0] lfsr_q;
    int errors, total_checks, waited, rst_seen, refs;
    dpr_link_if dpr_link_if_i ();
    dpr_ctrl dpr_ctrl_i (.link(dpr_link_if_i), .clock(clock),
        .resetn(resetn), .req_valid(req_valid), .req_cmd(req_cmd),
        .req_bank(req_bank), .req_ready(req_ready), .temp_hot(temp_hot),
        .slow_exit(1'b0), .odt_en(1'b1), .dll_locked(dll_locked),
        .bank_open(c_open), .power_down(c_pd), .self_refresh(c_sr),
        .refresh_due(), .dll_reset_req(rst_rq));
    dpr_dev dpr_dev_i (.link(dpr_link_if_i), .clock(clock),
        .resetn(resetn), .bank_open(d_open), .pd_precharge(pd_p),
        .pd_active(pd_a), .self_refresh(d_sr), .refreshing(refr),
        .dll_frozen(dll_fz), .buffers_on(buf_on), .exit_busy(busy),
        .cmd_error(cmd_err), .cke_error(cke_err));
    dpr_link_assertions dpr_link_assertions_i (.clock(clock),
        .resetn(resetn), .cke(dpr_link_if_i.cke), .cs_n(dpr_link_if_i.cs_n),
        .ras_n(dpr_link_if_i.ras_n), .cas_n(dpr_link_if_i.cas_n),
        .we_n(dpr_link_if_i.we_n), .ba(dpr_link_if_i.ba),
        .a10(dpr_link_if_i.a10), .odt(dpr_link_if_i.odt));
    // ==============================================================
    // clock, monitors and helpers
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        if (rst_rq === 1'b1) rst_seen++;
        if (dpr_link_if_i.cke && {dpr_link_if_i.cs_n, dpr_link_if_i.ras_n,
            dpr_link_if_i.cas_n, dpr_link_if_i.we_n} === 4'h1) refs++;
    end
    always @(negedge clock) begin
        if (resetn) chk("errs", 8'h00, {6'h00, cmd_err, cke_err});
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] st();
        return {c_pd, c_sr, pd_a, pd_p, d_sr, buf_on, dll_fz, refr};
    endfunction
    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic req(input dpr_req_t c, input logic [2:0] b);
        req_valid = 1'b1;
        req_cmd = c;
        req_bank = b;
        waited = 0;
        #1;
        while (req_ready !== 1'b1 && waited < 400) begin
            @(negedge clock);
            #1;
            waited++;
        end
        if (waited >= 400) errors++;
        @(posedge clock);
        if (c == REQ_ACT) m_open[b] = 1'b1;
        if (c == REQ_PRE) m_open[b] = 1'b0;
        if (c == REQ_PREA) m_open = 8'h00;
        @(negedge clock);
        req_valid = 1'b0;
        repeat (3) @(negedge clock);
    endtask
    task automatic close_out();
        if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #40000;
        errors++;
        close_out();
    end
    // ==============================================================
    // main sequence
    initial begin
        resetn = 1'b0;
        req_valid = 1'b0;
        req_cmd = REQ_NOP;
        req_bank = 3'h0;
        temp_hot = 1'b0;
        dll_locked = 1'b1;
        m_open = 8'h00;
        lfsr_q = 16'h321f;
        repeat (8) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        chk("open", m_open, d_open);
        for (int i = 0; i < 4; i++) begin
            lfsr_q = lfsr(lfsr_q);
            if (!m_open[lfsr_q[2:0]]) req(REQ_ACT, lfsr_q[2:0]);
        end
        req(REQ_PRE, lfsr_q[2:0]);
        chk("ctrl open", m_open, c_open);
        chk("dev open", m_open, d_open);
        req(REQ_READ, 3'h4);
        req(REQ_PD, 3'h0);
        chk("apd", 8'ha0, st());
        req(REQ_WAKE, 3'h0);
        chk("on", 8'h04, st());
        req(REQ_PREA, 3'h0);
        chk("prea", m_open, d_open);
        dll_locked = 1'b0;
        rst_seen = 0;
        req(REQ_PD, 3'h0);
        chk("ppd", 8'h92, st());
        req(REQ_WAKE, 3'h0);
        repeat (5) @(negedge clock);
        chk("dll reset", 8'h01, 8'(rst_seen));
        dll_locked = 1'b1;
        req(REQ_SR, 3'h0);
        chk("sr", 8'h49, st());
        req(REQ_WAKE, 3'h0);
        chk("exit busy", 8'h01, {7'h00, busy});
        req(REQ_ACT, 3'h1);
        chk("sr wait", 8'h01, {7'h00, waited > 190});
        req(REQ_PREA, 3'h0);
        temp_hot = 1'b1;
        refs = 0;
        repeat (1100) @(negedge clock);
        chk("hot ref", 8'h01, {7'h00, refs > 0});
        close_out();
    end
endmodule
